// *** sys_pin_pkg.sv ***
// Shared types and constants for the system pin mux and wake control block.
// Behaviour
// - One two-way pin carries EEPROM serial data.
// - Data pin muxes output, TX_EN, TX_CLK; select off.
// - Clock pin muxes output, RX_DV, RX_CLK; select off.
// - Both general outputs are output only.
// - Hardware reset clears power, write-gate and pin outputs; the crossover strap is not reset.
// - Writes ignored until a read after reset/wake.
// - Wake output asserts, programmable polarity and type.
// - Wake output never wakes the device itself.
// - Only qualified host write or reset leaves power saving.
// - Crossover enabled when strap high, disabled low.
package sys_pin_pkg;

	// ----------------------------------------------------------------
	// Pin mode encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PIN_EEPROM = 2'h0,
		PIN_GPO = 2'h1,
		PIN_MON_EN = 2'h2,
		PIN_MON_CLK = 2'h3
	} pin_mode_t;

	// ----------------------------------------------------------------
	// Power state machine
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PWR_AWAKE = 2'b01,
		PWR_SLEEP = 2'b10
	} pwr_state_t;

	// Internal MII signals watched by the monitor modes.
	typedef struct packed {
		logic txEn;
		logic txClk;
		logic rxDv;
		logic rxClk;
	} mii_mon_t;

	// EEPROM engine side of the two shared pins.
	typedef struct packed {
		logic dataOut;
		logic dataOe;
		logic clkOut;
		logic selOut;
	} eeprom_drv_t;

	localparam logic RST_WAKE_OUT = 1'b0;
	localparam logic RST_READ_SEEN = 1'b0;
	localparam logic RST_STRAP = 1'b1;
	localparam int SYNC_STAGES = 3;

endpackage

// *** sys_pin_ctrl.sv ***
// System pin mux, reset, wake-up and crossover strap control.
`timescale 1ns/100ps
module sys_pin_ctrl (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic hardwareResetLow,
	input wire logic softResetBit,
	input wire sys_pin_pkg::pin_mode_t dataPinMode,
	input wire sys_pin_pkg::pin_mode_t clkPinMode,
	input wire logic generalOutputThree,
	input wire logic generalOutputFour,
	input wire sys_pin_pkg::mii_mon_t miiMon,
	input wire sys_pin_pkg::eeprom_drv_t eepromDrv,
	input wire logic eepromSerialDataIn,
	input wire logic chipSelectLow,
	input wire logic writeStrobeLow,
	input wire logic readStrobeLow,
	input wire logic sleepRequest,
	input wire logic wakeEventDetect,
	input wire logic wakeOutEnable,
	input wire logic wakeOutPolarity,
	input wire logic wakeOutOpenDrain,
	input wire logic crossoverAutoStrap,
	output logic eepromSerialDataOut,
	output logic eepromSerialDataOe,
	output logic eepromSerialDataRx,
	output logic eepromClockOut,
	output logic eepromSelectOut,
	output logic wakeEventOut,
	output logic wakeEventOe,
	output logic writeEnabled,
	output logic powerSaving,
	output logic crossoverAutoEn,
	output logic logicReset
);
	import sys_pin_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// Pins come from outside; a change counts when stages two and three agree.
	logic [SYNC_STAGES-1:0] csSync_ff, wrSync_ff, rdSync_ff, rstSync_ff, strapSync_ff, dinSync_ff;
	logic csLow_ff, wrLow_ff, rdLow_ff, hwRstLow_ff, strap_ff, din_ff;

	function automatic logic filt(input logic [SYNC_STAGES-1:0] s, input logic prev);
		filt = (s[1] == s[2]) ? s[2] : prev;
	endfunction

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			csSync_ff <= '1;
			wrSync_ff <= '1;
			rdSync_ff <= '1;
			rstSync_ff <= '1;
			strapSync_ff <= '1;
			dinSync_ff <= '0;
			csLow_ff <= 1'b1;
			wrLow_ff <= 1'b1;
			rdLow_ff <= 1'b1;
			hwRstLow_ff <= 1'b1;
			strap_ff <= RST_STRAP;
			din_ff <= 1'b0;
		end else begin
			csSync_ff <= {csSync_ff[1:0], chipSelectLow};
			wrSync_ff <= {wrSync_ff[1:0], writeStrobeLow};
			rdSync_ff <= {rdSync_ff[1:0], readStrobeLow};
			rstSync_ff <= {rstSync_ff[1:0], hardwareResetLow};
			strapSync_ff <= {strapSync_ff[1:0], crossoverAutoStrap};
			dinSync_ff <= {dinSync_ff[1:0], eepromSerialDataIn};
			csLow_ff <= filt(csSync_ff, csLow_ff);
			wrLow_ff <= filt(wrSync_ff, wrLow_ff);
			rdLow_ff <= filt(rdSync_ff, rdLow_ff);
			hwRstLow_ff <= filt(rstSync_ff, hwRstLow_ff);
			strap_ff <= filt(strapSync_ff, strap_ff);
			din_ff <= filt(dinSync_ff, din_ff);
		end
	end

	// ----------------------------------------------------------------
	// Internal reset
	// ----------------------------------------------------------------
	// Hardware pin or soft bit clear the power, read and pin state below; not the strap or write-edge flop.
	logic intRst;
	assign intRst = ~hwRstLow_ff | softResetBit;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			logicReset <= 1'b1;
		end else begin
			logicReset <= intRst;
		end
	end

	// ----------------------------------------------------------------
	// Power state and write gating
	// ----------------------------------------------------------------
	logic hostWrite, hostWritePrev_ff, hostWriteEdge, hostRead;
	pwr_state_t pwrState_ff;
	logic readSeen_ff;

	assign hostWrite = ~csLow_ff & ~wrLow_ff;
	assign hostRead = ~csLow_ff & ~rdLow_ff;
	assign hostWriteEdge = hostWrite & ~hostWritePrev_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hostWritePrev_ff <= 1'b0;
		end else begin
			hostWritePrev_ff <= hostWrite;
		end
	end

	// Wake events are deliberately absent here: only a host write or an internal reset wakes.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pwrState_ff <= PWR_AWAKE;
		end else if (intRst) begin
			pwrState_ff <= PWR_AWAKE;
		end else begin
			case (pwrState_ff)
				PWR_AWAKE: begin
					if (sleepRequest) begin
						pwrState_ff <= PWR_SLEEP;
					end
				end
				PWR_SLEEP: begin
					if (hostWriteEdge) begin
						pwrState_ff <= PWR_AWAKE;
					end
				end
				default: begin
					pwrState_ff <= PWR_AWAKE;
				end
			endcase
		end
	end

	// Cleared by reset and on every cycle in sleep; set by a read only while awake.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			readSeen_ff <= RST_READ_SEEN;
		end else if (intRst) begin
			readSeen_ff <= RST_READ_SEEN;
		end else if (hostRead && pwrState_ff == PWR_AWAKE) begin
			readSeen_ff <= 1'b1;
		end else if (pwrState_ff == PWR_SLEEP) begin
			readSeen_ff <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			writeEnabled <= 1'b0;
			powerSaving <= 1'b0;
		end else begin
			writeEnabled <= readSeen_ff & ~intRst & (pwrState_ff == PWR_AWAKE);
			powerSaving <= (pwrState_ff == PWR_SLEEP);
		end
	end

	// ----------------------------------------------------------------
	// Wake event output
	// ----------------------------------------------------------------
	// Open-drain drives the pin only while the event is asserted, at its active level.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wakeEventOut <= RST_WAKE_OUT;
			wakeEventOe <= 1'b0;
		end else begin
			wakeEventOut <= (wakeOutEnable & wakeEventDetect & ~intRst) ~^ wakeOutPolarity;
			if (!wakeOutOpenDrain) begin
				wakeEventOe <= ~intRst;
			end else begin
				wakeEventOe <= ~intRst & wakeOutEnable & wakeEventDetect;
			end
		end
	end

	// ----------------------------------------------------------------
	// Shared pin multiplexers
	// ----------------------------------------------------------------
	function automatic logic monPick(input pin_mode_t m, input logic gpo, input logic en,
		input logic clk);
		case (m)
			PIN_GPO: monPick = gpo;
			PIN_MON_EN: monPick = en;
			PIN_MON_CLK: monPick = clk;
			default: monPick = 1'b0;
		endcase
	endfunction

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			eepromSerialDataOut <= 1'b0;
			eepromSerialDataOe <= 1'b0;
			eepromSerialDataRx <= 1'b0;
			eepromClockOut <= 1'b0;
			eepromSelectOut <= 1'b0;
		end else if (intRst) begin
			eepromSerialDataOut <= 1'b0;
			eepromSerialDataOe <= 1'b0;
			eepromSerialDataRx <= 1'b0;
			eepromClockOut <= 1'b0;
			eepromSelectOut <= 1'b0;
		end else begin
			eepromSerialDataRx <= din_ff;
			if (dataPinMode == PIN_EEPROM) begin
				eepromSerialDataOut <= eepromDrv.dataOut;
				eepromSerialDataOe <= eepromDrv.dataOe;
			end else begin
				// Output only: never released for input in these modes.
				eepromSerialDataOut <= monPick(dataPinMode, generalOutputThree, miiMon.txEn,
					miiMon.txClk);
				eepromSerialDataOe <= 1'b1;
			end
			if (clkPinMode == PIN_EEPROM) begin
				eepromClockOut <= eepromDrv.clkOut;
			end else begin
				eepromClockOut <= monPick(clkPinMode, generalOutputFour, miiMon.rxDv,
					miiMon.rxClk);
			end
			// Any alternate function keeps the EEPROM from being addressed by accident.
			eepromSelectOut <= eepromDrv.selOut & (dataPinMode == PIN_EEPROM)
				& (clkPinMode == PIN_EEPROM);
		end
	end

	// ----------------------------------------------------------------
	// Crossover strap
	// ----------------------------------------------------------------
	// An open strap pin floats high via its pull-up, so high or open enables.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			crossoverAutoEn <= RST_STRAP;
		end else begin
			crossoverAutoEn <= strap_ff;
		end
	end

endmodule

// *** sys_pin_ctrl_sva.sv ***
// Concurrent checks on the system pin mux and wake control ports.
`timescale 1ns/100ps
module sys_pin_ctrl_sva (
	input logic core_clk,
	input logic rst,
	input sys_pin_pkg::pin_mode_t dataPinMode,
	input sys_pin_pkg::pin_mode_t clkPinMode,
	input logic generalOutputThree,
	input sys_pin_pkg::mii_mon_t miiMon,
	input logic chipSelectLow,
	input logic writeStrobeLow,
	input logic readStrobeLow,
	input logic crossoverAutoStrap,
	input logic wakeOutEnable,
	input logic wakeEventDetect,
	input logic wakeOutPolarity,
	input logic wakeEventOut,
	input logic eepromSerialDataOut,
	input logic eepromSerialDataOe,
	input logic eepromClockOut,
	input logic eepromSelectOut,
	input logic writeEnabled,
	input logic powerSaving,
	input logic crossoverAutoEn,
	input logic logicReset
);
	import sys_pin_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_sel_data: assert property (dataPinMode != PIN_EEPROM |=> !eepromSelectOut)
		else $error("select on with data pin remapped");
	a_sel_clk: assert property (clkPinMode != PIN_EEPROM |=> !eepromSelectOut)
		else $error("select on with clock pin remapped");
	a_gpo_drive: assert property (dataPinMode == PIN_GPO |=> logicReset ||
		(eepromSerialDataOe && eepromSerialDataOut == $past(generalOutputThree)))
		else $error("data pin not driving its output value");
	a_clk_mon: assert property (clkPinMode == PIN_MON_CLK |=> logicReset ||
		eepromClockOut == $past(miiMon.rxClk)) else $error("clock pin not following monitor");
	a_wake_hold: assert property ((powerSaving && chipSelectLow)[*6] |=>
		powerSaving || logicReset) else $error("left power saving without host write");
	a_wake_exit: assert property ((powerSaving && !chipSelectLow && !writeStrobeLow)[*2]
		|-> ##[1:8] !powerSaving) else $error("host write did not wake");
	a_wr_gate: assert property ((!writeEnabled && readStrobeLow)[*8] |=> !writeEnabled)
		else $error("writes enabled without a read");
	a_xover_off: assert property ((!crossoverAutoStrap && !logicReset)[*6] |->
		!crossoverAutoEn) else $error("crossover on with strap low");
	a_wake_level: assert property (wakeOutEnable && wakeEventDetect |=> logicReset ||
		wakeEventOut == $past(wakeOutPolarity)) else $error("wake output not at active level");
endmodule
bind sys_pin_ctrl sys_pin_ctrl_sva chk (.*);

// *** eeprom_model.sv ***
// Behavioural serial EEPROM on the far side of the shared pins.
`timescale 1ns/100ps
module eeprom_model (
	input logic tick,
	input logic selectIn,
	input logic pinLevel,
	input logic hostDrive,
	output logic dataDrive
);
	logic lastBit = 1'b0;
	initial dataDrive = 1'b0;
	// The data line has no pull, so a released line keeps changing while deselected instead of holding.
	always @(posedge tick) begin
		if (selectIn && hostDrive) lastBit <= pinLevel;
		dataDrive <= selectIn ? ~lastBit : ~dataDrive;
	end
endmodule

// *** sys_pin_ctrl_tb_top.sv ***
// Self-checking bench for the system pin mux and wake control block.
`timescale 1ns/100ps
module sys_pin_ctrl_tb_top;
	import sys_pin_pkg::*;
	logic core_clk = 1'b0, rst = 1'b1, hardwareResetLow = 1'b1, softResetBit = 1'b0;
	logic generalOutputThree = 1'b0, generalOutputFour = 1'b0, chipSelectLow = 1'b1;
	logic writeStrobeLow = 1'b1, readStrobeLow = 1'b1, sleepRequest = 1'b0;
	logic wakeEventDetect = 1'b0, wakeOutEnable = 1'b0, wakeOutPolarity = 1'b0;
	logic wakeOutOpenDrain = 1'b0, crossoverAutoStrap = 1'b1;
	pin_mode_t dataPinMode = PIN_EEPROM, clkPinMode = PIN_EEPROM;
	mii_mon_t miiMon = '0;
	eeprom_drv_t eepromDrv = '0;
	logic eepromSerialDataIn, eepromSerialDataOut, eepromSerialDataOe, eepromSerialDataRx;
	logic eepromClockOut, eepromSelectOut, wakeEventOut, wakeEventOe, writeEnabled;
	logic powerSaving, crossoverAutoEn, logicReset, modelDrive, dOe, sel;
	logic [3:0] d, c;
	logic [31:0] seed = 32'ha570;
	int fails = 0, nTests = 0, cycles = 0;
	sys_pin_ctrl dut (.*);
	eeprom_model mem (.tick(eepromClockOut), .selectIn(eepromSelectOut), .pinLevel(eepromSerialDataIn),
		.hostDrive(eepromSerialDataOe), .dataDrive(modelDrive));
	assign eepromSerialDataIn = eepromSerialDataOe ? eepromSerialDataOut : modelDrive;
	function automatic logic [31:0] xs(logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic check(logic got, logic exp);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %b expected %b", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		if (fails == 0 && nTests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic hold(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// One host access held low across the pin synchronisers.
	task automatic host(logic rd, logic wr);
		{chipSelectLow, readStrobeLow, writeStrobeLow} = {1'b0, !rd, !wr};
		hold(3);
		{chipSelectLow, readStrobeLow, writeStrobeLow} = 3'b111;
		hold(8);
	endtask
	always #2 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails = fails + 1;
			end_sim();
		end
	end
	initial begin
		hold(4);
		rst = 1'b0;
		hold(6);
		for (int i = 0; i < 64; i++) begin
			seed = xs(seed);
			dataPinMode = pin_mode_t'(seed[1:0]);
			clkPinMode = pin_mode_t'(seed[3:2]);
			{miiMon, eepromDrv, generalOutputThree, generalOutputFour} = seed[13:4];
			d = {eepromDrv.dataOut, generalOutputThree, miiMon.txEn, miiMon.txClk};
			c = {eepromDrv.clkOut, generalOutputFour, miiMon.rxDv, miiMon.rxClk};
			dOe = dataPinMode != PIN_EEPROM || eepromDrv.dataOe;
			sel = dataPinMode == PIN_EEPROM && clkPinMode == PIN_EEPROM && eepromDrv.selOut;
			hold(1);
			check(eepromSelectOut, sel);
			check(eepromSerialDataOe, dOe);
			if (dOe) check(eepromSerialDataOut, d[3 - dataPinMode]);
			check(eepromClockOut, c[3 - clkPinMode]);
		end
		dataPinMode = PIN_GPO;
		for (int v = 0; v < 2; v++) begin
			crossoverAutoStrap = v[0];
			generalOutputThree = !v[0];
			hold(8);
			check(crossoverAutoEn, v[0]);
			check(eepromSerialDataRx, !v[0]);
		end
		check(writeEnabled, 1'b0);
		host(1'b1, 1'b0);
		check(writeEnabled, 1'b1);
		sleepRequest = 1'b1;
		hold(1);
		sleepRequest = 1'b0;
		hold(4);
		check(writeEnabled, 1'b0);
		{wakeOutEnable, wakeEventDetect} = 2'b11;
		for (int p = 0; p < 2; p++) begin
			wakeOutPolarity = p[0];
			hold(8);
			check(wakeEventOut, p[0]);
			check(wakeEventOe, 1'b1);
		end
		wakeOutOpenDrain = 1'b1;
		wakeEventDetect = 1'b0;
		hold(8);
		check(wakeEventOe, 1'b0);
		host(1'b1, 1'b0);
		check(powerSaving, 1'b1);
		host(1'b0, 1'b1);
		check(powerSaving, 1'b0);
		check(writeEnabled, 1'b0);
		for (int k = 0; k < 2; k++) begin
			{hardwareResetLow, softResetBit} = k ? 2'b11 : 2'b00;
			dataPinMode = PIN_EEPROM;
			clkPinMode = PIN_EEPROM;
			eepromDrv = 4'hf;
			hold(8);
			check(logicReset, 1'b1);
			check(eepromSelectOut, 1'b0);
			{hardwareResetLow, softResetBit} = 2'b10;
			hold(8);
			check(writeEnabled, 1'b0);
			check(eepromSelectOut, 1'b1);
		end
		end_sim();
	end
endmodule
